// [verilog/cmwd_decode.sv]
// Notes on behaviour
// - Address 00h selects interrupt enable word, 01h the interrupt flag word.
// - Status zero and one each answer at two addresses; native one is fully read/write.
// - Writes via a protected alias keep designated bits, update the rest.
// - Status zero: full at 02h, protected alias at 06h.
// - Status one: full at 03h, protected alias at 07h.
// - Status three full at 04h only; it has no protected alias.
// - Temp three, repeat start/end low and stack pointer each decode at two addresses.
// - Loading repeat counter one copies the same value into its save register.
// - The interrupt flag word is a full sixteen bits wide.
`timescale 1ns/1ns
`default_nettype none
module cmwd_decode
  import cmwd_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              acc_rd,
  input  wire logic              acc_wr,
  input  wire logic [ADDR_W-1:0] acc_addr,
  input  wire logic [DATA_W-1:0] acc_wdata,
  output logic      [DATA_W-1:0] acc_rdata,
  output logic                   acc_rvalid,
  output logic                   acc_unmapped,
  output logic      [DATA_W-1:0] status_three_out
);
  cmwd_regs_if rif ();

  cmwd_reg_store u_store (
    .clk   (clk),
    .rst_n (rst_n),
    .rif   (rif)
  );

  cmwd_sel_t         sel;
  logic              prot;
  logic [DATA_W-1:0] keep_mask;
  logic [DATA_W-1:0] old_word;
  logic              rd_pend_reg;
  logic              unmap_reg;
  logic [DATA_W-1:0] st3_out_reg;
  logic [DATA_W-1:0] wr_data_next;

  always_comb begin
    prot = 1'b0;
    unique case (acc_addr)
      ADR_IRQ_ENABLE_LO:  sel = CMWD_IRQ_EN;
      ADR_IRQ_FLAG_LO:    sel = CMWD_IRQ_FLAG;
      ADR_STATUS_ZERO:    sel = CMWD_STAT0;
      ADR_STATUS_ONE:     sel = CMWD_STAT1;
      ADR_STATUS_THREE:   sel = CMWD_STAT3;
      ADR_RESERVED_SLOT:  sel = CMWD_RES;
      ADR_STATUS_ZERO_PR: begin
        sel  = CMWD_STAT0;
        prot = 1'b1;
      end
      ADR_STATUS_ONE_PR: begin
        sel  = CMWD_STAT1;
        prot = 1'b1;
      end
      ADR_TEMP_THREE_A, ADR_TEMP_THREE_B: sel = CMWD_TEMP3;
      ADR_RPT_START_A, ADR_RPT_START_B:   sel = CMWD_RPT_START;
      ADR_RPT_END_A, ADR_RPT_END_B:       sel = CMWD_RPT_END;
      ADR_STACK_PTR_A, ADR_STACK_PTR_B:   sel = CMWD_STACK;
      ADR_RPT_COUNT_ONE:  sel = CMWD_RPT_CNT;
      ADR_RPT_COUNT_SAVE: sel = CMWD_RPT_SAVE;
      default:            sel = CMWD_NONE;
    endcase
  end

  always_comb begin
    unique case (sel)
      CMWD_STAT0: keep_mask = PROT_MASK_ZERO;
      CMWD_STAT1: keep_mask = PROT_MASK_ONE;
      default:  keep_mask = PROT_MASK_THREE;
    endcase
  end

  // Old contents are needed combinationally to merge a protected write; only
  // status zero and status one, through their protected aliases, take that path.
  always_comb begin
    unique case (sel)
      CMWD_STAT3: old_word = rif.st3_q;
      default:  old_word = rif.rd_data;
    endcase
  end

  always_comb begin
    if (prot) begin
      wr_data_next = (old_word & keep_mask) | (acc_wdata & ~keep_mask);
    end else begin
      wr_data_next = acc_wdata;
    end
  end

  // A protected write needs the stored word, so the store read port follows
  // the address every cycle; the merge uses the word latched the cycle before,
  // which requires the address to be held one cycle ahead of a protected write.
  always_comb begin
    rif.wr_en   = '0;
    rif.wr_data = wr_data_next;
    rif.rd_idx  = 4'(sel);
    if (acc_wr && sel != CMWD_NONE && sel != CMWD_RES) begin
      rif.wr_en[sel] = 1'b1;
      if (sel == CMWD_RPT_CNT) begin
        rif.wr_en[CMWD_RPT_SAVE] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_pend_reg <= 1'b0;
      unmap_reg   <= 1'b0;
    end else begin
      rd_pend_reg <= acc_rd;
      unmap_reg   <= (acc_rd || acc_wr) && (sel == CMWD_NONE || sel == CMWD_RES);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st3_out_reg <= RESET_WORD;
    end else begin
      st3_out_reg <= rif.st3_q;
    end
  end

  assign acc_rdata        = rif.rd_data;
  assign acc_rvalid       = rd_pend_reg;
  assign acc_unmapped     = unmap_reg;
  assign status_three_out = st3_out_reg;
endmodule : cmwd_decode
`default_nettype wire

// [verilog/cmwd_pkg.sv]
package cmwd_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 8;

  localparam logic [ADDR_W-1:0] ADR_IRQ_ENABLE_LO   = 8'h00;
  localparam logic [ADDR_W-1:0] ADR_IRQ_FLAG_LO     = 8'h01;
  localparam logic [ADDR_W-1:0] ADR_STATUS_ZERO     = 8'h02;
  localparam logic [ADDR_W-1:0] ADR_STATUS_ONE      = 8'h03;
  localparam logic [ADDR_W-1:0] ADR_STATUS_THREE    = 8'h04;
  localparam logic [ADDR_W-1:0] ADR_RESERVED_SLOT   = 8'h05;
  localparam logic [ADDR_W-1:0] ADR_STATUS_ZERO_PR  = 8'h06;
  localparam logic [ADDR_W-1:0] ADR_STATUS_ONE_PR   = 8'h07;
  localparam logic [ADDR_W-1:0] ADR_TEMP_THREE_A    = 8'h0E;
  localparam logic [ADDR_W-1:0] ADR_TEMP_THREE_B    = 8'h23;
  localparam logic [ADDR_W-1:0] ADR_STACK_PTR_A     = 8'h18;
  localparam logic [ADDR_W-1:0] ADR_STACK_PTR_B     = 8'h4D;
  localparam logic [ADDR_W-1:0] ADR_RPT_START_A     = 8'h1B;
  localparam logic [ADDR_W-1:0] ADR_RPT_START_B     = 8'h3D;
  localparam logic [ADDR_W-1:0] ADR_RPT_END_A       = 8'h1C;
  localparam logic [ADDR_W-1:0] ADR_RPT_END_B       = 8'h3F;
  localparam logic [ADDR_W-1:0] ADR_RPT_COUNT_ONE   = 8'h1A;
  localparam logic [ADDR_W-1:0] ADR_RPT_COUNT_SAVE  = 8'h1D;

  // Bits set in a mask are held at their old value on a protected-alias write.
  localparam logic [DATA_W-1:0] PROT_MASK_ZERO  = 16'h0000;
  localparam logic [DATA_W-1:0] PROT_MASK_ONE   = 16'h0000;
  localparam logic [DATA_W-1:0] PROT_MASK_THREE = 16'h0000;

  localparam logic [DATA_W-1:0] RESET_WORD  = 16'h0000;
  localparam logic [DATA_W-1:0] UNMAP_WORD  = 16'h0000;
  localparam int unsigned       NUM_REGS    = 13;

  typedef enum logic [3:0] {
    CMWD_IRQ_EN, CMWD_IRQ_FLAG, CMWD_STAT0, CMWD_STAT1, CMWD_STAT3, CMWD_TEMP3,
    CMWD_RPT_START, CMWD_RPT_END, CMWD_STACK, CMWD_RPT_CNT, CMWD_RPT_SAVE, CMWD_RES,
    CMWD_NONE
  } cmwd_sel_t;
endpackage : cmwd_pkg

// [verilog/cmwd_regs_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface cmwd_regs_if;
  import cmwd_pkg::*;
  logic [NUM_REGS-1:0] wr_en;
  logic [DATA_W-1:0]   wr_data;
  logic [3:0]          rd_idx;
  logic [DATA_W-1:0]   rd_data;
  logic [DATA_W-1:0]   st3_q;
  logic [DATA_W-1:0]   rpt_cnt_q;
  modport ctrl (output wr_en, output wr_data, output rd_idx, input rd_data,
                input st3_q, input rpt_cnt_q);
  modport store (input wr_en, input wr_data, input rd_idx, output rd_data,
                 output st3_q, output rpt_cnt_q);
endinterface : cmwd_regs_if
`default_nettype wire

// [verilog/cmwd_reg_store.sv]
`timescale 1ns/1ns
`default_nettype none
module cmwd_reg_store
  import cmwd_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst_n,
  cmwd_regs_if.store  rif
);
  logic [DATA_W-1:0] word_reg [NUM_REGS];
  logic [DATA_W-1:0] rd_reg;

  // One storage word per register: every alias address reads the same cell.
  for (genvar i = 0; i < NUM_REGS; i++) begin : g_word
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        word_reg[i] <= RESET_WORD;
      end else if (rif.wr_en[i]) begin
        word_reg[i] <= rif.wr_data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_reg <= RESET_WORD;
    end else if (rif.rd_idx < 4'(NUM_REGS)) begin
      rd_reg <= word_reg[rif.rd_idx];
    end else begin
      rd_reg <= UNMAP_WORD;
    end
  end

  assign rif.rd_data = rd_reg;
  assign rif.st3_q     = word_reg[CMWD_STAT3];
  assign rif.rpt_cnt_q = word_reg[CMWD_RPT_CNT];
endmodule : cmwd_reg_store
`default_nettype wire

// [tb/cmwd_decode_chk.sv]
`timescale 1ns/1ns
`default_nettype none
module cmwd_decode_chk
  import cmwd_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              acc_rd,
  input wire logic              acc_wr,
  input wire logic [ADDR_W-1:0] acc_addr,
  input wire logic [DATA_W-1:0] acc_wdata,
  input wire logic [DATA_W-1:0] acc_rdata,
  input wire logic              acc_rvalid,
  input wire logic              acc_unmapped,
  input wire logic [DATA_W-1:0] status_three_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // A write, two quiet cycles, then a read; the read data lands one edge later.
  sequence wr_rd(wa, ra);
    acc_wr && acc_addr == wa ##1 (!acc_wr)[*2] ##1 acc_rd && acc_addr == ra;
  endsequence
  rd_valid_a: assert property (acc_rd |=> acc_rvalid) else $error("read gave no valid");
  idle_valid_a: assert property (!acc_rd |=> !acc_rvalid) else $error("stray read valid");
  rsvd_flag_a: assert property ((acc_rd || acc_wr) && acc_addr == ADR_RESERVED_SLOT
    |=> acc_unmapped) else $error("reserved slot not flagged");
  rsvd_zero_a: assert property (acc_rd && acc_addr == ADR_RESERVED_SLOT
    |=> acc_rdata == UNMAP_WORD) else $error("reserved slot read not zero");
  flag_word_a: assert property (wr_rd(ADR_IRQ_FLAG_LO, ADR_IRQ_FLAG_LO)
    |=> acc_rdata == $past(acc_wdata, 4)) else $error("flag word lost bits");
  st0_alias_a: assert property (wr_rd(ADR_STATUS_ZERO, ADR_STATUS_ZERO_PR)
    |=> acc_rdata == $past(acc_wdata, 4)) else $error("status zero alias differs");
  st1_alias_a: assert property (wr_rd(ADR_STATUS_ONE_PR, ADR_STATUS_ONE)
    |=> acc_rdata == $past(acc_wdata, 4)) else $error("status one alias differs");
  t3_alias_a: assert property (wr_rd(ADR_TEMP_THREE_A, ADR_TEMP_THREE_B)
    |=> acc_rdata == $past(acc_wdata, 4)) else $error("temp three alias differs");
  brc_save_a: assert property (wr_rd(ADR_RPT_COUNT_ONE, ADR_RPT_COUNT_SAVE)
    |=> acc_rdata == $past(acc_wdata, 4)) else $error("save word not copied");
  st3_out_a: assert property (acc_wr && acc_addr == ADR_STATUS_THREE
    |=> ##1 status_three_out == $past(acc_wdata, 2)) else $error("status three out stale");
  cover property (wr_rd(ADR_RPT_COUNT_ONE, ADR_RPT_COUNT_SAVE));
  cover property (wr_rd(ADR_STATUS_ZERO, ADR_STATUS_ZERO_PR));
  cover property (acc_unmapped);
endmodule // cmwd_decode_chk
bind cmwd_decode cmwd_decode_chk chk_u (.clk, .rst_n, .acc_rd, .acc_wr, .acc_addr,
  .acc_wdata, .acc_rdata, .acc_rvalid, .acc_unmapped, .status_three_out);
`default_nettype wire

// [tb/cmwd_cpu_model.sv]
`timescale 1ns/1ns
`default_nettype none
module cmwd_cpu_model
  import cmwd_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [DATA_W-1:0] acc_rdata,
  input  wire logic              acc_rvalid,
  input  wire logic              acc_unmapped,
  output logic                   acc_rd,
  output logic                   acc_wr,
  output logic      [ADDR_W-1:0] acc_addr,
  output logic      [DATA_W-1:0] acc_wdata
);
  initial {acc_rd, acc_wr, acc_addr, acc_wdata} = '0;
  // The address leads the strobe by one edge so a protected write merges its own word.
  // The reserved slot is only touched when the caller names it.
  task automatic access(input logic w, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q, output logic v, output logic u);
    acc_addr <= a;
    acc_wdata <= d;
    @(posedge clk);
    acc_rd <= !w;
    acc_wr <= w;
    @(posedge clk);
    acc_rd <= 1'b0;
    acc_wr <= 1'b0;
    acc_wdata <= ~d;
    #1;
    q = acc_rdata;
    v = acc_rvalid;
    u = acc_unmapped;
    @(posedge clk);
  endtask
endmodule // cmwd_cpu_model
`default_nettype wire

// [tb/tb_cpu_mmr_window_decode.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_cpu_mmr_window_decode;
  import cmwd_pkg::*;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              acc_rd, acc_wr, acc_rvalid, acc_unmapped, v, u;
  logic [ADDR_W-1:0] acc_addr;
  logic [DATA_W-1:0] acc_wdata, acc_rdata, status_three_out, q;
  logic [DATA_W-1:0] mem [0:10];
  logic [7:0]        addrs [0:18] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07,
    8'h0E, 8'h23, 8'h18, 8'h4D, 8'h1B, 8'h3D, 8'h1C, 8'h3F, 8'h1A, 8'h1D, 8'h05, 8'h55};
  int                ids [0:18] = '{0, 1, 2, 3, 4, 2, 3, 5, 5, 6, 6, 7, 7, 8, 8, 9, 10, -1, -1};
  int                pairs [0:11][0:1] = '{'{1, 1}, '{2, 5}, '{6, 3}, '{7, 8}, '{4, 4},
    '{9, 10}, '{11, 12}, '{14, 13}, '{15, 16}, '{17, 17}, '{18, 18}, '{0, 0}};
  int                errors = 0;
  int                checks_done = 0;
  int                cyc = 0;
  cmwd_decode dut_u (.clk, .rst_n, .acc_rd, .acc_wr, .acc_addr, .acc_wdata, .acc_rdata,
    .acc_rvalid, .acc_unmapped, .status_three_out);
  cmwd_cpu_model cpu_u (.clk, .acc_rdata, .acc_rvalid, .acc_unmapped, .acc_rd, .acc_wr,
    .acc_addr, .acc_wdata);
  always #10 clk = ~clk;
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic give_verdict();
    if (errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic op(input logic w, input int i, input logic [15:0] d);
    int k = ids[i];
    // The bench fills the save word only through counter one, so direct writes become reads.
    if (k == 10) w = 1'b0;
    cpu_u.access(w, addrs[i], d, q, v, u);
    if (w && k >= 0) mem[k] = d;
    if (w && k == 9) mem[10] = d;
    if (!w) chk("rdata", k < 0 ? UNMAP_WORD : mem[k], q);
    chk("rvalid", {15'h0, !w}, {15'h0, v});
    chk("unmapped", {15'h0, k < 0}, {15'h0, u});
    #1;
    chk("status_three_out", mem[4], status_three_out);
  endtask
  always @(posedge clk) if (++cyc == 3000) begin
    errors++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'hDE9D));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    foreach (mem[j]) mem[j] = RESET_WORD;
    foreach (addrs[i]) op(1'b0, i, 16'h0000);
    foreach (pairs[j]) begin
      op(1'b1, pairs[j][0], 16'($urandom));
      op(1'b0, pairs[j][1], 16'h0000);
    end
    repeat (300) op(1'($urandom), $urandom_range(18), 16'($urandom));
    give_verdict();
  end
endmodule // tb_cpu_mmr_window_decode
`default_nettype wire
